// *** hdl/sff_framer_defines.vh ***
`ifndef SFF_FRAMER_DEFINES_VH
`define SFF_FRAMER_DEFINES_VH

// ----------------------------------------------------------------------
// Register indices on the plain register port
// ----------------------------------------------------------------------
`define SFF_REG_CONFIG 4'h0
`define SFF_REG_OUTSEL 4'h1
`define SFF_REG_CLAMP_LOW 4'h2
`define SFF_REG_CLAMP_HIGH 4'h3
`define SFF_REG_TICK_DIV 4'h4
`define SFF_REG_PAUSE_LEN 4'h5
`define SFF_REG_STATUS 4'h6
`define SFF_REG_LAST_CRC 4'h7
`define SFF_REG_FRAMES 4'h8

// ----------------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------------
`define SFF_CFG_FMT_HI 15
`define SFF_CFG_FMT_LO 14
`define SFF_CFG_CRC_SEL 11
`define SFF_CFG_PAUSE_EN 8
`define SFF_CFG_ERR_EN 6
`define SFF_CFG_SLOW_EN 4
`define SFF_CFG_RUN 0
`define SFF_OSEL_HI 9
`define SFF_OSEL_LO 8

// Fast channel format codes
`define SFF_FMT_SINGLE 2'h0
`define SFF_FMT_SECURE 2'h1
`define SFF_FMT_DUAL 2'h2
`define SFF_FMT_POS2 2'h3

// Second value selection codes
`define SFF_SEL_TEMP 2'h0
`define SFF_SEL_FIELD 2'h1
`define SFF_SEL_ANGLE 2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SFF_RST_CONFIG 16'h0000
`define SFF_RST_OUTSEL 16'h0000
`define SFF_RST_CLAMP_LOW 12'h000
`define SFF_RST_CLAMP_HIGH 12'hFFF
`define SFF_RST_PAUSE_LEN 8'h0C

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SFF_CLK_MHZ 100
`define SFF_TICK_NS 3000
`define SFF_TICK_CYCLES ((`SFF_TICK_NS * `SFF_CLK_MHZ + 999) / 1000)
`define SFF_SYNC_TICKS 8'd56
`define SFF_NIB_BASE_TICKS 8'd12
`define SFF_LOW_TICKS 8'd5
`define SFF_MIN_PAUSE_TICKS 8'd12
`define SFF_CRC_SEED 4'h5
`define SFF_CRC_POLY 4'hD

`endif

// *** hdl/sff_framer.v ***
// How it works
// - Two-channel formats send six data nibbles
// - Dual throttle: position then its negation
// - Dual throttle position clamped to limits
// - Position-sensor second value is selectable
// - Each frame opens with calibration pulse
// - Status nibble from error and slow settings
// - Pulses three to five: position, MSN first
// - Dual throttle negation sent LSN first
// - Selected second value sent LSN first
// - CRC nibble after data, variant selectable
// - Pause pulse only when enabled
// - Single channel sends three position nibbles
// - Two-bit field picks fast channel format
// - CRC bit: clear current, set legacy
// - Pause bit: clear continuous, set paused
// - Slow channel bit enables serial messages
`include "sff_framer_defines.vh"
`default_nettype none

module sff_framer (
  input wire sys_clk, // System clock, 100 MHz
  input wire srst, // Synchronous reset, active high
  input wire ce, // Clock enable, freezes all state when low
  input wire [3:0] reg_addr, // Register index
  input wire [15:0] reg_wdata, // Register write data
  input wire reg_we, // Write strobe
  input wire reg_re, // Read strobe
  output reg [15:0] reg_rdata, // Read data, one cycle after strobe
  input wire [11:0] position, // Measured position
  input wire [11:0] temperature, // Measured temperature
  input wire [11:0] field_amp, // Magnetic field amplitude
  input wire [11:0] angle2, // Second angle
  input wire [1:0] sensor_err, // Error indications for status bits 1:0
  input wire [1:0] serial_msg_bits, // Slow channel bits for status 3:2
  output reg sent_out, // SENT line, idle high
  output reg frame_start, // One-cycle pulse at each frame start
  output reg busy // High while a frame is running
);

  // ----------------------------------------------------------------------
  // CRC helper
  // ----------------------------------------------------------------------

  // One nibble shifted in at the low end, MSB first, as the table method does
  function [3:0] sff_crc_step;
    input [3:0] crc;
    input [3:0] nib;
    integer i;
    reg [3:0] c;
    reg fb;
    begin
      c = crc;
      for (i = 3; i >= 0; i = i - 1) begin
        fb = c[3];
        c = {c[2:0], nib[i]};
        if (fb) begin
          c = c ^ `SFF_CRC_POLY;
        end
      end
      sff_crc_step = c;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  localparam [31:0] TICK_DIV_FULL = `SFF_TICK_CYCLES;
  localparam [15:0] TICK_DIV_RST = TICK_DIV_FULL[15:0];
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg [15:0] cfg;
  reg [15:0] osel;
  reg [11:0] clamp_low;
  reg [11:0] clamp_high;
  reg [15:0] tick_div;
  reg [7:0] pause_len;
  reg [15:0] frames;
  reg [3:0] last_crc;

  wire [1:0] fmt = cfg[`SFF_CFG_FMT_HI:`SFF_CFG_FMT_LO];
  wire six_nib = fmt[1];
  wire [1:0] sel2 = osel[`SFF_OSEL_HI:`SFF_OSEL_LO];

  // ----------------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------------
  reg state;
  reg [15:0] tick_cnt;
  reg [7:0] tcnt;
  reg [7:0] pulse_len;
  reg [3:0] idx;
  reg [31:0] snap;
  reg [3:0] snap_ndata;
  reg snap_pause;

  reg next_state;
  reg [7:0] next_tcnt;
  reg [7:0] next_len;
  reg [3:0] next_idx;
  reg next_load;

  // Zero divider would stall the tick, so treat it as one
  wire [15:0] div_m1 = (tick_div == 16'h0000) ? 16'h0000 : tick_div - 16'h0001;
  wire tick = (state == ST_RUN) && (tick_cnt == div_m1);

  // ----------------------------------------------------------------------
  // Frame content captured at each frame start
  // ----------------------------------------------------------------------
  reg [11:0] pos_tx;
  reg [11:0] second;
  reg [3:0] status_nib;
  reg [23:0] data_nibs;
  reg [3:0] crc_calc;
  reg [3:0] ndata;
  integer k;

  // Snapshot keeps one frame consistent while the inputs move
  always @* begin
    pos_tx = position;
    second = temperature;
    status_nib = 4'h0;
    data_nibs = 24'h00_0000;
    crc_calc = `SFF_CRC_SEED;
    ndata = six_nib ? 4'd6 : 4'd3;
    if (fmt == `SFF_FMT_DUAL) begin
      if (position < clamp_low) begin
        pos_tx = clamp_low;
      end else if (position > clamp_high) begin
        pos_tx = clamp_high;
      end
      second = ~pos_tx;
    end else begin
      case (sel2)
        `SFF_SEL_TEMP: second = temperature;
        `SFF_SEL_FIELD: second = field_amp;
        `SFF_SEL_ANGLE: second = angle2;
        default: second = temperature;
      endcase
    end
    // Status bits 1:0 forced low unless error reporting is on
    if (cfg[`SFF_CFG_ERR_EN]) begin
      status_nib[1:0] = sensor_err;
    end
    if (cfg[`SFF_CFG_SLOW_EN]) begin
      status_nib[3:2] = serial_msg_bits;
    end
    // Data nibbles in transmit order, first in the low bits
    data_nibs[3:0] = pos_tx[11:8];
    data_nibs[7:4] = pos_tx[7:4];
    data_nibs[11:8] = pos_tx[3:0];
    data_nibs[15:12] = second[3:0];
    data_nibs[19:16] = second[7:4];
    data_nibs[23:20] = second[11:8];
    for (k = 0; k < 6; k = k + 1) begin
      if (k < ndata) begin
        crc_calc = sff_crc_step(crc_calc, data_nibs[k*4 +: 4]);
      end
    end
    // Current CRC appends a zero nibble, legacy CRC does not
    if (!cfg[`SFF_CFG_CRC_SEL]) begin
      crc_calc = sff_crc_step(crc_calc, 4'h0);
    end
  end

  // ----------------------------------------------------------------------
  // Pulse sequencer
  // ----------------------------------------------------------------------
  reg [3:0] cur_nib;
  reg last_pulse;

  // Pulse index: 0 sync, 1 status, data, CRC, then optional pause
  always @* begin
    next_state = state;
    next_tcnt = tcnt;
    next_len = pulse_len;
    next_idx = idx;
    next_load = 1'b0;
    cur_nib = 4'h0;
    last_pulse = 1'b0;
    // Nibble of the pulse that follows the current one
    if (idx <= snap_ndata + 4'd1) begin
      cur_nib = snap[idx*4 +: 4];
    end
    if (snap_pause) begin
      last_pulse = (idx == snap_ndata + 4'd3);
    end else begin
      last_pulse = (idx == snap_ndata + 4'd2);
    end
    case (state)
      ST_IDLE: begin
        if (cfg[`SFF_CFG_RUN]) begin
          next_state = ST_RUN;
          next_load = 1'b1;
          next_tcnt = 8'd0;
          next_idx = 4'd0;
          next_len = `SFF_SYNC_TICKS;
        end
      end
      ST_RUN: begin
        if (tick) begin
          if (tcnt != pulse_len - 8'd1) begin
            next_tcnt = tcnt + 8'd1;
          end else if (last_pulse) begin
            // Back-to-back frame: falling edge here opens the next sync
            next_tcnt = 8'd0;
            next_idx = 4'd0;
            next_len = `SFF_SYNC_TICKS;
            if (cfg[`SFF_CFG_RUN]) begin
              next_load = 1'b1;
            end else begin
              next_state = ST_IDLE;
            end
          end else begin
            next_tcnt = 8'd0;
            next_idx = idx + 4'd1;
            if (idx + 4'd1 == snap_ndata + 4'd3) begin
              next_len = (pause_len < `SFF_MIN_PAUSE_TICKS) ?
                `SFF_MIN_PAUSE_TICKS : pause_len;
            end else begin
              next_len = `SFF_NIB_BASE_TICKS + {4'h0, cur_nib};
            end
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Clocked state
  // ----------------------------------------------------------------------

  // Tick prescaler, runs only inside frames
  always @(posedge sys_clk) begin
    if (srst) begin
      tick_cnt <= 16'h0000;
    end else if (ce) begin
      if (state != ST_RUN || tick) begin
        tick_cnt <= 16'h0000;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
      end
    end
  end

  // Sequencer registers and the line itself
  always @(posedge sys_clk) begin
    if (srst) begin
      state <= ST_IDLE;
      tcnt <= 8'd0;
      pulse_len <= `SFF_SYNC_TICKS;
      idx <= 4'd0;
      snap <= 32'h0000_0000;
      snap_ndata <= 4'd3;
      snap_pause <= 1'b0;
      sent_out <= 1'b1;
      frame_start <= 1'b0;
      busy <= 1'b0;
      frames <= 16'h0000;
      last_crc <= 4'h0;
    end else if (ce) begin
      state <= next_state;
      tcnt <= next_tcnt;
      pulse_len <= next_len;
      idx <= next_idx;
      frame_start <= next_load;
      busy <= (next_state == ST_RUN);
      // Low phase of each pulse, then high for the remainder
      sent_out <= !((next_state == ST_RUN) && (next_tcnt < `SFF_LOW_TICKS));
      if (next_load) begin
        snap <= {4'h0, crc_calc, data_nibs[23:0]} << 4;
        snap[3:0] <= status_nib;
        if (ndata == 4'd3) begin
          snap[19:16] <= crc_calc;
          snap[31:20] <= 12'h000;
        end else begin
          snap[31:28] <= crc_calc;
        end
        snap_ndata <= ndata;
        snap_pause <= cfg[`SFF_CFG_PAUSE_EN];
        frames <= frames + 16'h0001;
        last_crc <= crc_calc;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------

  // Writes; frame settings apply from the next frame start, tick_div at once and pause_len from the next pause pulse
  always @(posedge sys_clk) begin
    if (srst) begin
      cfg <= `SFF_RST_CONFIG;
      osel <= `SFF_RST_OUTSEL;
      clamp_low <= `SFF_RST_CLAMP_LOW;
      clamp_high <= `SFF_RST_CLAMP_HIGH;
      tick_div <= TICK_DIV_RST;
      pause_len <= `SFF_RST_PAUSE_LEN;
    end else if (ce && reg_we) begin
      case (reg_addr)
        `SFF_REG_CONFIG: cfg <= reg_wdata;
        `SFF_REG_OUTSEL: osel <= reg_wdata;
        `SFF_REG_CLAMP_LOW: clamp_low <= reg_wdata[11:0];
        `SFF_REG_CLAMP_HIGH: clamp_high <= reg_wdata[11:0];
        `SFF_REG_TICK_DIV: tick_div <= reg_wdata;
        `SFF_REG_PAUSE_LEN: pause_len <= reg_wdata[7:0];
        default: cfg <= cfg;
      endcase
    end
  end

  // Reads; unmapped indices answer zero
  always @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      if (reg_re) begin
        case (reg_addr)
          `SFF_REG_CONFIG: reg_rdata <= cfg;
          `SFF_REG_OUTSEL: reg_rdata <= osel;
          `SFF_REG_CLAMP_LOW: reg_rdata <= {4'h0, clamp_low};
          `SFF_REG_CLAMP_HIGH: reg_rdata <= {4'h0, clamp_high};
          `SFF_REG_TICK_DIV: reg_rdata <= tick_div;
          `SFF_REG_PAUSE_LEN: reg_rdata <= {8'h00, pause_len};
          `SFF_REG_STATUS: reg_rdata <= {7'h00, busy, 4'h0, idx};
          `SFF_REG_LAST_CRC: reg_rdata <= {12'h000, last_crc};
          `SFF_REG_FRAMES: reg_rdata <= frames;
          default: reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

endmodule // sff_framer

`default_nettype wire

// *** tb/sff_framer_asserts.sv ***
`default_nettype none
// ------------------------------
// Port checker for the framer
// ------------------------------
module sff_framer_asserts #(
  parameter int TICK = 2
) (
  input wire logic sys_clk, // Clock
  input wire logic srst, // Reset
  input wire logic reg_re, // Read strobe
  input wire logic [3:0] reg_addr, // Index
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic sent_out, // Line
  input wire logic frame_start, // Frame pulse
  input wire logic busy // Frame running
);
  timeunit 1ns;
  timeprecision 1ps;
  // Delays in cycles, valid only once the tick divider is written
  localparam int LOW1 = 5 * TICK - 1;
  localparam int LOWC = 5 * TICK;
  localparam int SYNH = 51 * TICK;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Line rules
  reset_idle_a: assert property (disable iff (1'b0) srst |=> sent_out && !busy)
    else $error("line not idle after reset");
  low_time_a: assert property ($fell(sent_out) |-> ##LOW1 !sent_out ##1 sent_out)
    else $error("low phase length wrong");
  sync_len_a: assert property (frame_start |-> ##LOWC sent_out ##SYNH !sent_out)
    else $error("sync pulse length wrong");
  start_state_a: assert property (frame_start |-> !sent_out && busy)
    else $error("frame start without low line");
  start_pulse_a: assert property (frame_start |=> !frame_start)
    else $error("frame start longer than one cycle");
  busy_rise_a: assert property ($rose(busy) |-> frame_start)
    else $error("busy rose without frame start");
  idle_line_a: assert property (!busy |-> sent_out)
    else $error("line low while idle");
  // Register port rules
  rdata_quiet_a: assert property (!reg_re |=> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  unmapped_rd_a: assert property (reg_re && reg_addr > 4'h8 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule // sff_framer_asserts
`default_nettype wire

// *** tb/sff_ecu.sv ***
`default_nettype none
// ------------------------------
// Receiving control unit model
// ------------------------------
module sff_ecu #(
  parameter int TICK = 2
) (
  input wire logic sys_clk, // Clock
  input wire logic sent_out // Received line
);
  timeunit 1ns;
  timeprecision 1ps;
  int per_q[$]; // Fall to fall periods in ticks
  int cnt = 0;
  int hi = 0;
  logic prev = 1'b1;
  logic armed = 1'b0;
  int cal = 0; // Sync length in cycles, zero until calibrated
  // Sync calibrates the tick; the sync itself is held against the nominal tick
  // Long idle disarms, so a fresh frame never pairs with an old edge
  always @(posedge sys_clk) begin
    prev <= sent_out;
    cnt <= cnt + 1;
    hi <= sent_out ? hi + 1 : 0;
    if (hi > 60 * TICK) begin
      armed <= 1'b0;
      cal <= 0;
    end
    if (prev && !sent_out) begin
      if (armed && cal == 0) begin
        cal <= cnt;
        per_q.push_back(cnt / TICK);
      end else if (armed) begin
        per_q.push_back((cnt * 56 + cal / 2) / cal);
      end
      armed <= 1'b1;
      cnt <= 1;
    end
  end
endmodule // sff_ecu
`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [11:0] position = 12'h000;
  logic [11:0] vals[4] = '{12'h123, 12'h456, 12'h789, 12'h123};
  logic [1:0] sensor_err = 2'h1;
  logic [1:0] serial_msg_bits = 2'h2;
  wire [15:0] reg_rdata;
  wire sent_out;
  wire frame_start;
  wire busy;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 sys_clk = ~sys_clk;
  sff_framer uut (.sys_clk(sys_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .position(position), .temperature(vals[0]), .field_amp(vals[1]), .angle2(vals[2]),
    .sensor_err(sensor_err), .serial_msg_bits(serial_msg_bits), .sent_out(sent_out),
    .frame_start(frame_start), .busy(busy));
  sff_ecu #(.TICK(2)) ecu (.sys_clk(sys_clk), .sent_out(sent_out));
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    @(negedge sys_clk);
    check(reg_rdata, exp);
  endtask
  // Two frames so the first one's last pulse is closed by a falling edge
  task automatic run_frame(input logic [15:0] cfg, input logic [11:0] pos,
      input logic [11:0] px, input logic [11:0] sec, input logic [3:0] st, input int plen);
    logic [3:0] e[10];
    logic [3:0] c;
    int nd;
    int k;
    int s2;
    nd = cfg[15] ? 6 : 3;
    e = '{st, px[11:8], px[7:4], px[3:0], sec[3:0], sec[7:4], sec[11:8], 0, 0, 0};
    c = 4'h5;
    for (int i = 1; i <= nd + (cfg[11] ? 0 : 1); i++) begin
      for (int b = 3; b >= 0; b--) begin
        c = {c[2:0], (i > nd) ? 1'b0 : e[i][b]} ^ (c[3] ? 4'hD : 4'h0);
      end
    end
    e[nd + 1] = c;
    // Long idle disarms the receiver, so no edge of the last run pairs up
    repeat (130) @(posedge sys_clk);
    position <= pos;
    ecu.per_q.delete();
    wr(4'h0, cfg | 16'h0001);
    k = 0;
    repeat (4000) if (k < 2) begin
      @(negedge sys_clk);
      if (frame_start === 1'b1) k++;
    end
    wr(4'h0, 16'h0000);
    repeat (2000) if (busy !== 1'b0) @(negedge sys_clk);
    check(16'(k), 16'h0002);
    check({15'h0000, busy}, 16'h0000);
    check(16'(ecu.per_q[0]), 16'h0038);
    for (int i = 0; i <= nd + 1; i++) begin
      check(16'(ecu.per_q[i + 1] - 12), {12'h000, e[i]});
    end
    check(16'(ecu.per_q[nd + 3]), cfg[8] ? 16'(plen) : 16'h0038);
    // Second frame follows with no gap: its sync and data once more
    s2 = nd + (cfg[8] ? 4 : 3);
    check(16'(ecu.per_q[s2]), 16'h0038);
    for (int i = 0; i <= nd; i++) begin
      check(16'(ecu.per_q[s2 + i + 1] - 12), {12'h000, e[i]});
    end
    rd(4'h7, {12'h000, c});
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs;
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    rd(4'h2, 16'h0000);
    rd(4'h3, 16'h0FFF);
    rd(4'h4, 16'h012C);
    rd(4'h5, 16'h000C);
    wr(4'h8, 16'h00FF);
    rd(4'h8, 16'h0000);
    rd(4'hF, 16'h0000);
    wr(4'h2, 16'h0100);
    wr(4'h3, 16'h0E00);
    rd(4'h2, 16'h0100);
    rd(4'h3, 16'h0E00);
    rd(4'h6, 16'h0000);
    // Writes while the enable is low must be lost
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(4'h2, 16'h0ABC);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(4'h2, 16'h0100);
    wr(4'h4, 16'h0002);
    $display("test regs done");
  endtask
  task automatic t_dual;
    run_frame(16'h8050, 12'hF12, 12'hE00, 12'h1FF, 4'h9, 0);
    run_frame(16'h8900, 12'h023, 12'h100, 12'hEFF, 4'h0, 12);
    $display("test dual done");
  endtask
  // Clamp limits stay set: this format must ignore them
  task automatic t_pos2;
    for (int s = 0; s < 4; s++) begin
      wr(4'h1, {6'h00, 2'(s), 8'h00});
      run_frame(16'hC000, 12'hF12, 12'hF12, vals[s], 4'h0, 0);
    end
    $display("test pos2 done");
  endtask
  task automatic t_single;
    wr(4'h5, 16'h0014);
    run_frame(16'h0100, 12'h5A3, 12'h5A3, 12'h000, 4'h0, 20);
    run_frame(16'h4000, 12'h3C6, 12'h3C6, 12'h000, 4'h0, 0);
    $display("test single done");
  endtask
  // Reset in mid-frame: line idle at once, settings back to their reset values
  task automatic t_reset;
    wr(4'h0, 16'hC001);
    repeat (300) @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) begin
      @(negedge sys_clk);
      check({14'h0000, busy, sent_out}, 16'h0001);
    end
    rd(4'h0, 16'h0000);
    rd(4'h4, 16'h012C);
    rd(4'h8, 16'h0000);
    $display("test reset done");
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_dual();
    t_pos2();
    t_single();
    t_reset();
    stop_test();
  end
endmodule // tb_top
bind sff_framer sff_framer_asserts #(.TICK(2)) u_chk (.sys_clk(sys_clk), .srst(srst),
  .reg_re(reg_re), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .sent_out(sent_out),
  .frame_start(frame_start), .busy(busy));
`default_nettype wire
